// ### hdl/host_port_control.sv
// host port control register and quadlet read stacking
// assumes host pins are synchronous to sys_clk_in and the internal
// register logic answers a read with rd_resp_valid_in one pulse
// How it works
// - control register at 1ECh, bits 0-7
// - bit 0 selects byte or word access
// - bit 1 selects big or little endian
// - bit 2 sets interrupt polarity
// - bit 3 sets acknowledge drive type
// - byte host reads acknowledge drive as zero
// - bit 4 sets interrupt drive type
// - bit 5 enables polled access mode
// - bit 6 byte order, ignored when big
// - bit 7 sets acknowledge polarity
// - cycle starts on chip select, handshake waits
// - polled host ends early, polls status 1F0h
// - new quadlet read fetches whole aligned quadlet
// - wait internal response, then acknowledge data
// - buffered quadlet serves other positions
// - internal read latency at most 19 clocks
// - rereading a read position refetches quadlet
// - a write started in idle invalidates the read buffer
// - host bus bit 0 is most significant
`timescale 1ns/1ns
`include "host_port_defs.svh"

module host_port_control
#(
   parameter int ADDR_W = 9
)
(
   input  wire logic                        sys_clk_in,
   input  wire logic                        rst_b_in,
   input  wire logic                        host_type_sel_hi_in,
   input  wire logic                        host_type_sel_lo_in,
   input  wire host_port_pkg::host_req_t    host_req_in,
   input  wire logic [31:0]                 rd_resp_data_in,
   input  wire logic                        rd_resp_valid_in,
   input  wire logic                        irq_event_in,
   output logic [15:0]                      host_rdata_out,
   output logic                             host_rdata_oe_n_out,
   output logic                             ack_out,
   output logic                             ack_oe_n_out,
   output logic                             irq_out,
   output logic                             irq_oe_n_out,
   output logic                             rd_req_out,
   output logic [ADDR_W-1:0]                rd_addr_out,
   output logic                             wr_seen_out,
   output host_port_pkg::host_ctrl_t        ctrl_out
);

   // elaboration check: the host address struct is nine bits wide
   if (ADDR_W != 9)
   begin : g_addr_w_chk
      $error("host_port_control: ADDR_W must be 9");
   end

   // ==========================================================
   // decode
   logic [1:0] host_type;
   logic       cs_act;
   logic       cs_prev_r;
   logic       cs_start;
   logic       is_rd;
   logic       is_wr;
   logic       stat_hit;
   logic [ADDR_W-1:0] q_addr;

   assign host_type = {host_type_sel_hi_in, host_type_sel_lo_in};
   assign cs_act    = ~host_req_in.chip_select_n;
   assign cs_start  = cs_act & ~cs_prev_r;
   assign is_rd     = cs_start & ~host_req_in.write;
   assign is_wr     = cs_start & host_req_in.write;
   assign q_addr    = {host_req_in.addr[ADDR_W-1:2], 2'h0};
   assign stat_hit  = (q_addr == `HP_STAT_OFFSET);

   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
         cs_prev_r <= 1'b0;
      else
         cs_prev_r <= cs_act;
   end

   // ==========================================================
   // control register
   host_port_pkg::host_ctrl_t ctrl_r;
   logic [7:0] ctrl_stack_r;
   logic       ctrl_hit;
   logic       ctrl_done;
   logic [7:0] rst_img;
   logic       bytes_mode;

   assign ctrl_hit   = is_wr & (q_addr == `HP_CTRL_OFFSET);
   assign bytes_mode = ctrl_r.byte_access_sel;

   always_comb
   begin
      unique case (host_type)
         `HP_TYPE_WORD16: rst_img = `HP_RST_WORD16;
         `HP_TYPE_BYTE8:  rst_img = `HP_RST_BYTE8;
         default:         rst_img = `HP_RST_EXT;
      endcase
   end

   // quadlet complete on last byte lane (byte) or last word (word)
   assign ctrl_done = bytes_mode ? (host_req_in.addr[1:0] == 2'h3) : host_req_in.addr[1];

   // bit 0 is the msb lane, so the option field sits in the lane at offset 0
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
         ctrl_stack_r <= 8'h00;
      else if (ctrl_hit && host_req_in.addr[1:0] == 2'h0)
         ctrl_stack_r <= bytes_mode ? host_req_in.wdata[7:0] : host_req_in.wdata[15:8];
   end

   logic rst_seen_r;
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         rst_seen_r <= 1'b0;
         ctrl_r     <= '0;
      end
      else if (!rst_seen_r)
      begin
         rst_seen_r <= 1'b1;
         ctrl_r     <= host_port_pkg::host_ctrl_t'(rst_img);
      end
      else if (ctrl_hit && ctrl_done)
      begin
         ctrl_r <= host_port_pkg::host_ctrl_t'(ctrl_stack_r);
         if (host_type == `HP_TYPE_BYTE8)
            ctrl_r.ack_drive_mode <= 1'b0;
      end
   end

   // ==========================================================
   // read stacking buffer
   logic [31:0]       buf_r;
   logic [ADDR_W-1:0] buf_addr_r;
   logic              buf_vld_r;
   logic [3:0]        read_mask_r;
   logic [3:0]        lane_mask;
   logic              need_fetch;
   host_port_pkg::port_state_t st_r;
   logic [`HP_LAT_W-1:0] lat_r;
   logic              polled_busy_r;

   always_comb
   begin
      if (bytes_mode)
         lane_mask = 4'h1 << host_req_in.addr[1:0];
      else
         lane_mask = host_req_in.addr[1] ? 4'hc : 4'h3;
   end

   // the status register lives in the port, so reading it never fetches
   assign need_fetch = ~stat_hit & (~buf_vld_r | (q_addr != buf_addr_r)
                     | ((read_mask_r & lane_mask) != 4'h0));

   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         st_r          <= host_port_pkg::ST_IDLE;
         rd_req_out    <= 1'b0;
         rd_addr_out   <= '0;
         buf_vld_r     <= 1'b0;
         buf_r         <= 32'h0;
         buf_addr_r    <= '0;
         read_mask_r   <= 4'h0;
         lat_r         <= '0;
         polled_busy_r <= 1'b0;
      end
      else
      begin
         rd_req_out <= 1'b0;
         unique case (st_r)
            host_port_pkg::ST_IDLE:
            begin
               if (is_wr)
               begin
                  buf_vld_r <= 1'b0;
                  st_r      <= host_port_pkg::ST_ACK;
               end
               else if (is_rd && stat_hit)
                  st_r <= host_port_pkg::ST_ACK;
               else if (is_rd && need_fetch)
               begin
                  rd_req_out    <= 1'b1;
                  rd_addr_out   <= q_addr;
                  buf_addr_r    <= q_addr;
                  buf_vld_r     <= 1'b0;
                  read_mask_r   <= lane_mask;
                  lat_r         <= '0;
                  polled_busy_r <= 1'b1;
                  st_r          <= host_port_pkg::ST_WAIT;
               end
               else if (is_rd)
               begin
                  read_mask_r <= read_mask_r | lane_mask;
                  st_r        <= host_port_pkg::ST_ACK;
               end
            end
            host_port_pkg::ST_WAIT:
            begin
               lat_r <= lat_r + `HP_LAT_W'(1);
               if (rd_resp_valid_in)
               begin
                  buf_r         <= rd_resp_data_in;
                  buf_vld_r     <= 1'b1;
                  polled_busy_r <= 1'b0;
                  st_r          <= host_port_pkg::ST_ACK;
               end
            end
            host_port_pkg::ST_ACK:
               st_r <= host_port_pkg::ST_HOLD;
            host_port_pkg::ST_HOLD:
            begin
               if (!cs_act || ctrl_r.polled_access_enable)
                  st_r <= host_port_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // host data, acknowledge and interrupt pins
   logic [15:0] sel_data;
   logic [31:0] swapped;

   // little endian with address invariance swaps bytes; big endian ignores bit 6
   assign swapped = (!ctrl_r.big_endian_sel && !ctrl_r.data_invariant_sel)
                  ? {buf_r[7:0], buf_r[15:8], buf_r[23:16], buf_r[31:24]} : buf_r;

   always_comb
   begin
      if (ctrl_r.byte_access_sel)
         sel_data = {8'h00, swapped[31 - 8*host_req_in.addr[1:0] -: 8]};
      else
         sel_data = host_req_in.addr[1] ? swapped[15:0] : swapped[31:16];
   end

   logic ack_act;
   assign ack_act = (st_r == host_port_pkg::ST_ACK) | (st_r == host_port_pkg::ST_HOLD);

   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         host_rdata_out      <= 16'h0;
         host_rdata_oe_n_out <= 1'b1;
         ack_out             <= 1'b0;
         ack_oe_n_out        <= 1'b1;
         irq_out             <= 1'b0;
         irq_oe_n_out        <= 1'b1;
         wr_seen_out         <= 1'b0;
         ctrl_out            <= '0;
      end
      else
      begin
         wr_seen_out <= is_wr;
         ctrl_out    <= ctrl_r;
         if (cs_act && !host_req_in.write && stat_hit)
            host_rdata_out <= {15'h0, polled_busy_r};
         else if (cs_act && !host_req_in.write && q_addr == `HP_CTRL_OFFSET)
            host_rdata_out <= ctrl_r.byte_access_sel ? {8'h00, ctrl_r} : {ctrl_r, 8'h00};
         else
            host_rdata_out <= sel_data;
         host_rdata_oe_n_out <= ~(cs_act & ~host_req_in.write & ack_act);
         ack_out      <= ack_act ~^ ctrl_r.ack_polarity;
         ack_oe_n_out <= ~(ctrl_r.ack_drive_mode | ack_act);
         irq_out      <= irq_event_in ~^ ctrl_r.irq_polarity;
         irq_oe_n_out <= ~(ctrl_r.irq_drive_mode | irq_event_in);
      end
   end

   // ==========================================================
   // checks
   property p_lat;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (st_r == host_port_pkg::ST_WAIT) |-> (lat_r < `HP_LAT_W'(`HP_RD_LAT_MAX));
   endproperty
   a_lat: assert property (p_lat) else $error("read latency exceeded");

   property p_wr_inval;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (is_wr && st_r == host_port_pkg::ST_IDLE) |=> !buf_vld_r;
   endproperty
   a_wr_inval: assert property (p_wr_inval) else $error("write kept buffer");

   property p_fetch;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (is_rd && need_fetch && st_r == host_port_pkg::ST_IDLE) |=> rd_req_out && rd_addr_out[1:0] == 2'h0;
   endproperty
   a_fetch: assert property (p_fetch) else $error("no aligned fetch");

   property p_hit;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (is_rd && !need_fetch && st_r == host_port_pkg::ST_IDLE) |=> !rd_req_out;
   endproperty
   a_hit: assert property (p_hit) else $error("buffer hit refetched");

   property p_ack_after_resp;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (st_r == host_port_pkg::ST_WAIT && rd_resp_valid_in) |=> ##1 ack_out == ctrl_r.ack_polarity;
   endproperty
   a_ack_after_resp: assert property (p_ack_after_resp) else $error("ack missing");

   property p_byte_ackdrv;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (host_type == `HP_TYPE_BYTE8 && rst_seen_r && $past(rst_seen_r)) |-> !ctrl_r.ack_drive_mode;
   endproperty
   a_byte_ackdrv: assert property (p_byte_ackdrv) else $error("ack drive bit set");

   property p_irq_pol;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      $stable(ctrl_r.irq_polarity) |=> irq_out == ($past(irq_event_in) ~^ $past(ctrl_r.irq_polarity));
   endproperty
   a_irq_pol: assert property (p_irq_pol) else $error("irq polarity wrong");

   property p_ack_drv;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      ctrl_r.ack_drive_mode |=> !ack_oe_n_out;
   endproperty
   a_ack_drv: assert property (p_ack_drv) else $error("ack not push pull");

   property p_wr_ack;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (is_wr && st_r == host_port_pkg::ST_IDLE) |=> ##1 ack_out == ctrl_r.ack_polarity;
   endproperty
   a_wr_ack: assert property (p_wr_ack) else $error("write not acknowledged");

   property p_stat_local;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (is_rd && stat_hit && st_r == host_port_pkg::ST_IDLE) |=> !rd_req_out && st_r == host_port_pkg::ST_ACK;
   endproperty
   a_stat_local: assert property (p_stat_local) else $error("status read fetched");

   property p_rdata_drive;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (st_r == host_port_pkg::ST_ACK && cs_act && !host_req_in.write) |=> !host_rdata_oe_n_out;
   endproperty
   a_rdata_drive: assert property (p_rdata_drive) else $error("read data not driven");

endmodule

// ### hdl/host_port_defs.svh
// constants for the host port control and read stacking block
// assumes inclusion by the host port control module and its testbench only
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// ==========================================================
// register offsets (byte addresses in configuration space)
`define HP_CTRL_OFFSET      9'h1ec
`define HP_STAT_OFFSET      9'h1f0

// ==========================================================
// control register fields
`define HP_BIT_BYTE_ACC     0
`define HP_BIT_BIG_END      1
`define HP_BIT_IRQ_POL      2
`define HP_BIT_ACK_DRV      3
`define HP_BIT_IRQ_DRV      4
`define HP_BIT_POLLED       5
`define HP_BIT_DATA_INV     6
`define HP_BIT_ACK_POL      7
`define HP_CTRL_FIELD_W     8

// ==========================================================
// host type select codes
`define HP_TYPE_EXT         2'h0
`define HP_TYPE_WORD16      2'h1
`define HP_TYPE_BYTE8       2'h2
`define HP_TYPE_RSVD        2'h3

// ==========================================================
// reset images of the control field per host type
`define HP_RST_EXT          8'h72
`define HP_RST_WORD16       8'h42
`define HP_RST_BYTE8        8'h61

// ==========================================================
// timing
`define HP_RD_LAT_MAX       19
`define HP_LAT_W            5

`endif

// ### hdl/host_port_pkg.sv
// types for the host port control and read stacking block
// assumes nothing beyond the defs header
package host_port_pkg;

   // ==========================================================
   // control register option field
   typedef struct packed
   {
      logic ack_polarity;
      logic data_invariant_sel;
      logic polled_access_enable;
      logic irq_drive_mode;
      logic ack_drive_mode;
      logic irq_polarity;
      logic big_endian_sel;
      logic byte_access_sel;
   } host_ctrl_t;

   // ==========================================================
   // host cycle request as seen at the pins
   typedef struct packed
   {
      logic       chip_select_n;
      logic       write;
      logic [8:0] addr;
      logic [15:0] wdata;
   } host_req_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_ACK  = 2'b10,
      ST_HOLD = 2'b11
   } port_state_t;

endpackage

// ### sim/internal_regs_model.sv
// behavioural model of the internal register logic behind the host port
// assumes one read request at a time and a response delay set by the bench
`timescale 1ns/1ns

module internal_regs_model
(
   input  wire logic        sys_clk_in,
   input  wire logic        rd_req_in,
   input  wire logic [8:0]  rd_addr_in,
   input  wire logic [4:0]  delay_in,
   output logic             rd_resp_valid_out,
   output logic [31:0]      rd_resp_data_out
);
   logic        busy_r;
   logic [4:0]  cnt_r;
   logic [8:0]  addr_r;
   logic [15:0] serial_r;

   // ==========================================================
   // read responder
   initial
   begin
      busy_r = 1'b0;
      cnt_r = 5'h00;
      addr_r = 9'h000;
      serial_r = 16'h0000;
      rd_resp_valid_out = 1'b0;
      rd_resp_data_out = 32'h0000_0000;
   end

   always @(posedge sys_clk_in)
   begin
      rd_resp_valid_out <= 1'b0;
      // data is only meaningful in the valid cycle
      rd_resp_data_out <= ~rd_resp_data_out;
      if (busy_r)
      begin
         if (cnt_r == 5'h00)
         begin
            rd_resp_valid_out <= 1'b1;
            rd_resp_data_out <= {7'h00, addr_r, serial_r};
            serial_r <= serial_r + 16'h0001;
            busy_r <= 1'b0;
         end
         else
            cnt_r <= cnt_r - 5'h01;
      end
      else if (rd_req_in)
      begin
         busy_r <= 1'b1;
         cnt_r <= delay_in;
         addr_r <= rd_addr_in;
      end
   end
endmodule

// ### sim/host_port_control_tb.sv
// self-checking bench for the host port control and read stacking block
// assumes the design and model files are compiled ahead of this one
`timescale 1ns/1ns
`include "host_port_defs.svh"

module host_port_control_tb;
   logic                      sys_clk, rst_b, sel_hi, sel_lo, irq_event, ack_hi, polled;
   logic                      resp_valid, rd_req, wr_seen, ack, ack_oe_n, irq, irq_oe_n, rdata_oe_n;
   logic [31:0]               resp_data;
   logic [15:0]               rdata, rd;
   logic [8:0]                rd_addr, last_ra;
   logic [4:0]                delay;
   host_port_pkg::host_req_t  req;
   host_port_pkg::host_ctrl_t ctrl;
   int                        err_total, n_compared, nf, nw, lat, i;
   logic [7:0]                exp_def [4] = '{8'h72, 8'h42, 8'h61, 8'h72};
   logic [7:0]                msk [4] = '{8'hff, 8'hef, 8'hff, 8'hff};

   host_port_control DUT (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .host_type_sel_hi_in(sel_hi),
      .host_type_sel_lo_in(sel_lo), .host_req_in(req), .rd_resp_data_in(resp_data),
      .rd_resp_valid_in(resp_valid), .irq_event_in(irq_event), .host_rdata_out(rdata),
      .host_rdata_oe_n_out(rdata_oe_n), .ack_out(ack), .ack_oe_n_out(ack_oe_n), .irq_out(irq),
      .irq_oe_n_out(irq_oe_n), .rd_req_out(rd_req), .rd_addr_out(rd_addr), .wr_seen_out(wr_seen),
      .ctrl_out(ctrl));

   internal_regs_model partner (.sys_clk_in(sys_clk), .rd_req_in(rd_req), .rd_addr_in(rd_addr),
      .delay_in(delay), .rd_resp_valid_out(resp_valid), .rd_resp_data_out(resp_data));

   // ==========================================================
   // clock, fetch monitor, watchdog
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
      if (rst_b === 1'b1 && rd_req === 1'b1)
      begin
         nf++;
         last_ra = rd_addr;
      end

   always @(posedge sys_clk)
      if (rst_b === 1'b1 && wr_seen === 1'b1)
         nw++;

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      summarize;
   end

   // ==========================================================
   // compare and report
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   task chk_n(input string n, input int e, input int g);
      n_compared++;
      if (g != e)
      begin
         err_total++;
         $display("FAIL %s expected %0d seen %0d", n, e, g);
      end
   endtask

   task summarize;
      if (err_total == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================================
   // host cycles
   task do_reset(input logic [1:0] t);
      @(posedge sys_clk);
      #1 rst_b = 1'b0;
      {sel_hi, sel_lo} = t;
      repeat (6) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   task cyc(input logic w, input logic [8:0] a, input logic [15:0] d);
      int k;
      k = 0;
      lat = 0;
      @(posedge sys_clk);
      #1 req = '{1'b0, w, a, d};
      if (polled)
      begin
         repeat (6) @(posedge sys_clk);
         #1;
      end
      else
      begin
         while (k == 0 && lat < 40)
         begin
            @(posedge sys_clk);
            #1 lat++;
            if (ack === ack_hi)
               k = 1;
         end
         chk_n("ack seen", 1, k);
         if (!w)
            chk("rdata oe", 16'h0000, {15'h0000, rdata_oe_n});
      end
      rd = rdata;
      req.chip_select_n = 1'b1;
      req.write = 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask

   // ==========================================================
   // tests
   initial
   begin
      rst_b = 1'b0;
      {sel_hi, sel_lo} = 2'h0;
      irq_event = 1'b0;
      delay = 5'h01;
      polled = 1'b1;
      ack_hi = 1'b0;
      req = '{1'b1, 1'b0, 9'h000, 16'h0000};
      err_total = 0;
      n_compared = 0;
      nf = 0;
      nw = 0;
      for (i = 1; i < 5; i++)
      begin
         do_reset(2'(i % 4));
         chk("ctrl default", {8'h00, exp_def[i % 4]}, {8'h00, ctrl & msk[i % 4]});
      end
      chk("ack oe idle", 16'h0001, {15'h0000, ack_oe_n});
      cyc(1'b1, `HP_CTRL_OFFSET, 16'hda00);
      cyc(1'b1, 9'h1ee, 16'h0000);
      repeat (4) @(posedge sys_clk);
      chk("ctrl", 16'h00da, {8'h00, ctrl});
      polled = 1'b0;
      ack_hi = 1'b1;
      chk("ack idle", 16'h0000, {14'h0000, ack, ack_oe_n});
      cyc(1'b0, 9'h0f2, 16'h0000);
      chk("low half", 16'h0000, rd);
      chk("fetch addr", 16'h00f0, {7'h00, last_ra});
      chk_n("latency ok", 1, int'(lat <= 19));
      cyc(1'b0, 9'h0f0, 16'h0000);
      chk("high half", 16'h00f0, rd);
      chk_n("fetches", 1, nf);
      cyc(1'b0, 9'h0f2, 16'h0000);
      chk_n("fetches", 2, nf);
      chk("refetch", 16'h0001, rd);
      delay = 5'h0c;
      cyc(1'b0, 9'h0f6, 16'h0000);
      chk_n("fetches", 3, nf);
      chk("slow read", 16'h0002, rd);
      chk_n("slow latency ok", 1, int'(lat <= 19));
      cyc(1'b1, 9'h100, 16'h1234);
      cyc(1'b0, 9'h0f4, 16'h0000);
      chk_n("fetches", 4, nf);
      chk("after write", 16'h00f4, rd);
      cyc(1'b1, `HP_CTRL_OFFSET, 16'hdb00);
      cyc(1'b1, 9'h1ee, 16'h0000);
      repeat (4) @(posedge sys_clk);
      chk("ctrl byte", 16'h00db, {8'h00, ctrl});
      cyc(1'b0, 9'h0fb, 16'h0000);
      chk_n("fetches", 5, nf);
      chk("byte3", 16'h0004, {8'h00, rd[7:0]});
      cyc(1'b0, 9'h0f9, 16'h0000);
      chk_n("fetches", 5, nf);
      chk("byte1", 16'h00f8, {8'h00, rd[7:0]});
      #1 irq_event = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 chk("irq pin", 16'h0000, {14'h0000, irq, irq_oe_n});
      for (i = 0; i < 4; i++)
         cyc(1'b1, 9'(`HP_CTRL_OFFSET + i), (i == 0) ? 16'h00c7 : 16'h0000);
      repeat (4) @(posedge sys_clk);
      #1 chk("irq high", 16'h0002, {14'h0000, irq, irq_oe_n});
      irq_event = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 chk("irq released", 16'h0001, {14'h0000, irq, irq_oe_n});
      do_reset(2'h2);
      polled = 1'b1;
      for (i = 0; i < 4; i++)
         cyc(1'b1, 9'(`HP_CTRL_OFFSET + i), (i == 0) ? 16'h0069 : 16'h0000);
      repeat (4) @(posedge sys_clk);
      chk("ctrl byte host", 16'h0061, {8'h00, ctrl});
      cyc(1'b0, 9'h0f0, 16'h0000);
      cyc(1'b0, `HP_STAT_OFFSET, 16'h0000);
      chk("status busy", 16'h0001, rd);
      repeat (20) @(posedge sys_clk);
      cyc(1'b0, `HP_STAT_OFFSET, 16'h0000);
      chk("status idle", 16'h0000, rd);
      chk_n("writes", 13, nw);
      summarize;
   end
endmodule
